// *** spectral_limit_trigger.v ***
// spectral limit trigger: mask evaluation per spectrum and trigger ports
`timescale 1ns/1ps
`default_nettype none
`include "spectral_limit_trigger_defs.vh"
module spectral_limit_trigger #(
  parameter DEPTH = 1001,
  parameter IW    = `PT_IDX_W,
  parameter PW    = `POS_W,
  parameter AW    = `AMP_W,
  parameter LW    = 16
) (
  input  wire          clk_sys_i,
  input  wire          rst_n_i,
  // configuration
  input  wire [2:0]    trig_source_i,
  input  wire          slope_falling_i,
  input  wire          mask_cond_i,
  input  wire          upper_sel_i,
  input  wire          lower_sel_i,
  input  wire          rel_mode_i,
  input  wire [AW-1:0] ref_level_i,
  input  wire [AW-1:0] auto_dist_i,
  // mask point loading
  input  wire          pt_wr_i,
  input  wire          pt_wr_lower_i,
  input  wire [IW-1:0] pt_idx_i,
  input  wire [PW-1:0] pt_pos_i,
  input  wire [AW-1:0] pt_amp_i,
  input  wire [10:0]   upper_count_i,
  input  wire [10:0]   lower_count_i,
  input  wire          shift_x_i,
  input  wire          shift_y_i,
  input  wire          shift_lower_i,
  input  wire [PW-1:0] shift_w_i,
  input  wire [AW-1:0] shift_h_i,
  input  wire          auto_set_i,
  // spectrum stream, one bin per cycle, bins in rising position
  input  wire          bin_valid_i,
  input  wire [PW-1:0] bin_pos_i,
  input  wire [AW-1:0] bin_amp_i,
  input  wire          bin_last_i,
  // other trigger sources
  input  wire          level_src_i,
  // trigger ports
  input  wire          trig1_pin_i,
  input  wire          trig2_dir_out_i,
  input  wire          trig3_dir_out_i,
  input  wire [1:0]    trig2_otype_i,
  input  wire [1:0]    trig3_otype_i,
  input  wire          trig2_level_i,
  input  wire          trig3_level_i,
  input  wire [LW-1:0] trig2_pulse_len_i,
  input  wire [LW-1:0] trig3_pulse_len_i,
  input  wire          trig2_send_i,
  input  wire          trig3_send_i,
  input  wire          trig2_pin_i,
  input  wire          trig3_pin_i,
  output wire          trig2_pin_o,
  output wire          trig2_pin_oe_o,
  output wire          trig3_pin_o,
  output wire          trig3_pin_oe_o,
  output reg           capture_trig_o,
  output reg           mask_armed_o,
  output reg           frame_inside_o,
  output wire [15:0]   oper_status_o
);
  reg  [IW-1:0] seg_ff;
  reg  [IW-1:0] auto_idx_ff;
  reg           auto_busy_ff;
  reg           hit_ff;
  reg           armed_ff;
  reg           prev_src_ff;
  reg  [IW-1:0] lo_seg_ff;
  reg  [2:0]    src_sel_ff;
  reg           edge_ok_ff;
  reg           nxt_hit;
  wire          t2_ext;
  wire          t3_ext;
  wire [PW-1:0] up_pos_a;
  wire [AW-1:0] up_amp_a;
  wire [PW-1:0] lo_pos_a;
  wire [AW-1:0] lo_amp_a;
  wire [PW-1:0] up_pos_b;
  wire [AW-1:0] up_amp_b;
  wire [PW-1:0] lo_pos_b;
  wire [AW-1:0] lo_amp_b;
  wire [IW-1:0] seg_nx = seg_ff + {{(IW-1){1'b0}}, 1'b1};
  wire [IW-1:0] lo_seg_nx = lo_seg_ff + {{(IW-1){1'b0}}, 1'b1};
  wire          up_ok = upper_count_i >= `MIN_POINTS && upper_count_i <= `MAX_POINTS;
  wire          lo_ok = lower_count_i >= `MIN_POINTS && lower_count_i <= `MAX_POINTS;
  wire          up_on = upper_sel_i && up_ok;
  wire          lo_on = lower_sel_i && lo_ok;
  // while auto set runs, software writes to the upper table are dropped
  wire          up_wr = (pt_wr_i && !pt_wr_lower_i) || auto_busy_ff;
  wire [IW-1:0] up_wr_idx = auto_busy_ff ? auto_idx_ff : pt_idx_i;
  wire [AW-1:0] up_wr_amp = auto_busy_ff ? (bin_amp_i + auto_dist_i) : pt_amp_i;
  wire [PW-1:0] up_wr_pos = auto_busy_ff ? bin_pos_i : pt_pos_i;
  wire          auto_last = auto_busy_ff && bin_valid_i && bin_last_i;

  // two copies of each table give both segment ends in one cycle
  mask_point_store #(.DEPTH(DEPTH), .IW(IW), .PW(PW), .AW(AW)) u_upper (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (up_wr && (!auto_busy_ff || bin_valid_i)),
    .wr_idx_i  (up_wr_idx),
    .wr_pos_i  (up_wr_pos),
    .wr_amp_i  (up_wr_amp),
    .shift_x_i (shift_x_i && !shift_lower_i),
    .shift_y_i (shift_y_i && !shift_lower_i),
    .shift_w_i (shift_w_i),
    .shift_h_i (shift_h_i),
    .rd_idx_i  (seg_ff),
    .rd_pos_o  (up_pos_a),
    .rd_amp_o  (up_amp_a)
  );
  mask_point_store #(.DEPTH(DEPTH), .IW(IW), .PW(PW), .AW(AW)) u_upper_b (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (up_wr && (!auto_busy_ff || bin_valid_i)),
    .wr_idx_i  (up_wr_idx),
    .wr_pos_i  (up_wr_pos),
    .wr_amp_i  (up_wr_amp),
    .shift_x_i (shift_x_i && !shift_lower_i),
    .shift_y_i (shift_y_i && !shift_lower_i),
    .shift_w_i (shift_w_i),
    .shift_h_i (shift_h_i),
    .rd_idx_i  (seg_nx),
    .rd_pos_o  (up_pos_b),
    .rd_amp_o  (up_amp_b)
  );
  // lower tables are written only by software, never by auto set
  mask_point_store #(.DEPTH(DEPTH), .IW(IW), .PW(PW), .AW(AW)) u_lower (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (pt_wr_i && pt_wr_lower_i),
    .wr_idx_i  (pt_idx_i),
    .wr_pos_i  (pt_pos_i),
    .wr_amp_i  (pt_amp_i),
    .shift_x_i (shift_x_i && shift_lower_i),
    .shift_y_i (shift_y_i && shift_lower_i),
    .shift_w_i (shift_w_i),
    .shift_h_i (shift_h_i),
    .rd_idx_i  (lo_seg_ff),
    .rd_pos_o  (lo_pos_a),
    .rd_amp_o  (lo_amp_a)
  );
  mask_point_store #(.DEPTH(DEPTH), .IW(IW), .PW(PW), .AW(AW)) u_lower_b (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (pt_wr_i && pt_wr_lower_i),
    .wr_idx_i  (pt_idx_i),
    .wr_pos_i  (pt_pos_i),
    .wr_amp_i  (pt_amp_i),
    .shift_x_i (shift_x_i && shift_lower_i),
    .shift_y_i (shift_y_i && shift_lower_i),
    .shift_w_i (shift_w_i),
    .shift_h_i (shift_h_i),
    .rd_idx_i  (lo_seg_nx),
    .rd_pos_o  (lo_pos_b),
    .rd_amp_o  (lo_amp_b)
  );

  // limit at position p on segment a..b; signed amplitudes, one divide per table per bin
  function [AW-1:0] interp;
    input [PW-1:0] pa;
    input [AW-1:0] aa;
    input [PW-1:0] pb;
    input [AW-1:0] ab;
    input [PW-1:0] p;
    reg signed [AW+PW+1:0] num;
    reg signed [AW+PW+1:0] den;
    reg signed [AW+PW+1:0] quo;
    begin
      // wide enough that slope times offset never wraps
      num = ($signed({{(PW+2){ab[AW-1]}}, ab}) - $signed({{(PW+2){aa[AW-1]}}, aa})) *
            $signed({{(AW+2){1'b0}}, p - pa});
      den = $signed({{(AW+2){1'b0}}, pb - pa});
      if (den == {(AW+PW+2){1'b0}})
        den = {{(AW+PW+1){1'b0}}, 1'b1};
      quo    = num / den;
      interp = aa + quo[AW-1:0];
    end
  endfunction

  // relative masks are offset by the reference level
  function [AW-1:0] absolute;
    input [AW-1:0] a;
    begin
      absolute = rel_mode_i ? (a + ref_level_i) : a;
    end
  endfunction

  // a bin outside the point range is unmasked
  wire          up_in_rng = bin_pos_i >= up_pos_a && bin_pos_i <= up_pos_b &&
                            {1'b0, seg_nx} < upper_count_i;
  wire          lo_in_rng = bin_pos_i >= lo_pos_a && bin_pos_i <= lo_pos_b &&
                            {1'b0, lo_seg_nx} < lower_count_i;
  wire [AW-1:0] up_lim = absolute(interp(up_pos_a, up_amp_a, up_pos_b, up_amp_b, bin_pos_i));
  wire [AW-1:0] lo_lim = absolute(interp(lo_pos_a, lo_amp_a, lo_pos_b, lo_amp_b, bin_pos_i));
  wire          up_hit = up_on && up_in_rng &&
                         $signed(bin_amp_i) > $signed(up_lim);
  wire          lo_hit = lo_on && lo_in_rng &&
                         $signed(bin_amp_i) < $signed(lo_lim);
  // each table walks its own segments; bins rise in position, one step per bin
  wire          up_adv = bin_valid_i && upper_sel_i && bin_pos_i >= up_pos_b &&
                         {1'b0, seg_nx} < upper_count_i;
  wire          lo_adv = bin_valid_i && lower_sel_i && bin_pos_i >= lo_pos_b &&
                         {1'b0, lo_seg_nx} < lower_count_i;
  wire          frame_end = bin_valid_i && bin_last_i;
  wire          frame_in  = hit_ff || up_hit || lo_hit;
  wire          mask_src  = trig_source_i == `SRC_FREQ_MASK;
  wire          fire_mask = mask_src && frame_end && armed_ff && (up_on || lo_on) &&
                            (mask_cond_i == `COND_ENTERING ? frame_in : !frame_in);
  // port 1 is input only, so it only ever feeds this selection
  wire          ext_src   = trig_source_i == `SRC_EXT1 ? trig1_pin_i :
                            trig_source_i == `SRC_EXT2 ? t2_ext :
                            trig_source_i == `SRC_EXT3 ? t3_ext :
                            trig_source_i == `SRC_TIME_DOMAIN ? level_src_i : 1'b0;
  // slope only matters for edge sources; the previous sample must come from the
  // same source after reset, or a pin idling high would read as an edge
  wire          fire_edge = !mask_src && trig_source_i != `SRC_FREE_RUN &&
                            edge_ok_ff && src_sel_ff == trig_source_i &&
                            (slope_falling_i ? (prev_src_ff && !ext_src)
                                             : (!prev_src_ff && ext_src));

  // hit flag gathers the bins of one frame and clears at its last bin
  always @* begin
    nxt_hit = hit_ff;
    if (bin_valid_i)
      nxt_hit = frame_end ? 1'b0 : frame_in;
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seg_ff         <= {IW{1'b0}};
      hit_ff         <= 1'b0;
      armed_ff       <= 1'b0;
      prev_src_ff    <= 1'b0;
      capture_trig_o <= 1'b0;
      frame_inside_o <= 1'b0;
      mask_armed_o   <= 1'b0;
      auto_busy_ff   <= 1'b0;
      auto_idx_ff    <= {IW{1'b0}};
      lo_seg_ff      <= {IW{1'b0}};
      src_sel_ff     <= 3'h0;
      edge_ok_ff     <= 1'b0;
    end else begin
      hit_ff      <= nxt_hit;
      prev_src_ff <= ext_src;
      src_sel_ff  <= trig_source_i;
      edge_ok_ff  <= 1'b1;
      // one cycle wide; the port pulses are stretched downstream
      capture_trig_o <= fire_mask || fire_edge;
      mask_armed_o   <= mask_src ? armed_ff : 1'b0;
      // a frame end restarts both segment walks
      if (frame_end) begin
        seg_ff         <= {IW{1'b0}};
        lo_seg_ff      <= {IW{1'b0}};
        frame_inside_o <= frame_in;
      end else begin
        if (up_adv)
          seg_ff <= seg_nx;
        if (lo_adv)
          lo_seg_ff <= lo_seg_nx;
      end
      // arming needs one frame on the opposite side of the condition
      if (!mask_src || !(up_on || lo_on))
        armed_ff <= 1'b0;
      else if (frame_end)
        armed_ff <= (mask_cond_i == `COND_ENTERING) ? !frame_in : frame_in;
      // auto set captures the bins from the next valid one up to a frame end, at most DEPTH of them, into the upper mask
      if (auto_set_i && !auto_busy_ff) begin
        auto_busy_ff <= 1'b1;
        auto_idx_ff  <= {IW{1'b0}};
      end else if (auto_busy_ff && bin_valid_i) begin
        auto_idx_ff <= auto_idx_ff + {{(IW-1){1'b0}}, 1'b1};
        if (auto_last || auto_idx_ff == DEPTH - 1)
          auto_busy_ff <= 1'b0;
      end
    end
  end

  // ports 2 and 3 share the capture and armed signals
  trig_out_port #(.LW(LW)) u_trig2 (
    .clk_sys_i    (clk_sys_i),
    .rst_n_i      (rst_n_i),
    .dir_out_i    (trig2_dir_out_i),
    .otype_i      (trig2_otype_i),
    .idle_level_i (trig2_level_i),
    .pulse_len_i  (trig2_pulse_len_i),
    .dev_trig_i   (capture_trig_o),
    .armed_i      (mask_armed_o),
    .send_i       (trig2_send_i),
    .pin_i        (trig2_pin_i),
    .pin_o        (trig2_pin_o),
    .pin_oe_o     (trig2_pin_oe_o),
    .ext_trig_o   (t2_ext)
  );
  trig_out_port #(.LW(LW)) u_trig3 (
    .clk_sys_i    (clk_sys_i),
    .rst_n_i      (rst_n_i),
    .dir_out_i    (trig3_dir_out_i),
    .otype_i      (trig3_otype_i),
    .idle_level_i (trig3_level_i),
    .pulse_len_i  (trig3_pulse_len_i),
    .dev_trig_i   (capture_trig_o),
    .armed_i      (mask_armed_o),
    .send_i       (trig3_send_i),
    .pin_i        (trig3_pin_i),
    .pin_o        (trig3_pin_o),
    .pin_oe_o     (trig3_pin_oe_o),
    .ext_trig_o   (t3_ext)
  );

  assign oper_status_o = {10'h000, mask_armed_o, 5'h00};
endmodule // spectral_limit_trigger
`default_nettype wire

// *** spectral_limit_trigger_defs.vh ***
// constants for the spectral limit trigger unit
`ifndef SPECTRAL_LIMIT_TRIGGER_DEFS_VH
`define SPECTRAL_LIMIT_TRIGGER_DEFS_VH
`define MIN_POINTS        11'h002
`define MAX_POINTS        11'h3e9
`define PT_IDX_W          10
`define POS_W             16
`define AMP_W             16
`define SRC_FREE_RUN      3'h0
`define SRC_EXT1          3'h1
`define SRC_EXT2          3'h2
`define SRC_EXT3          3'h3
`define SRC_FREQ_MASK     3'h4
`define SRC_TIME_DOMAIN   3'h5
`define COND_ENTERING     1'b0
`define COND_LEAVING      1'b1
`define OTYPE_DEVICE      2'h0
`define OTYPE_ARMED       2'h1
`define OTYPE_USER        2'h2
`define ARMED_STATUS_BIT  5
`define AUTO_DISTANCE     16'h000a
`endif

// *** mask_point_store.v ***
// one mask point table with shift and load operations
`timescale 1ns/1ps
`default_nettype none
`include "spectral_limit_trigger_defs.vh"
module mask_point_store #(
  parameter DEPTH = 1001,
  parameter IW    = 10,
  parameter PW    = 16,
  parameter AW    = 16
) (
  input  wire          clk_sys_i,
  input  wire          rst_n_i,
  input  wire          wr_en_i,
  input  wire [IW-1:0] wr_idx_i,
  input  wire [PW-1:0] wr_pos_i,
  input  wire [AW-1:0] wr_amp_i,
  input  wire          shift_x_i,
  input  wire          shift_y_i,
  input  wire [PW-1:0] shift_w_i,
  input  wire [AW-1:0] shift_h_i,
  input  wire [IW-1:0] rd_idx_i,
  output reg  [PW-1:0] rd_pos_o,
  output reg  [AW-1:0] rd_amp_o
);
  reg [PW-1:0] pos_ff [0:DEPTH-1];
  reg [AW-1:0] amp_ff [0:DEPTH-1];
  integer i;
  // each entry holds a position and an amplitude
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        pos_ff[i] <= {PW{1'b0}};
        amp_ff[i] <= {AW{1'b0}};
      end
    end else begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        if (wr_en_i && wr_idx_i == i[IW-1:0]) begin
          pos_ff[i] <= wr_pos_i;
          amp_ff[i] <= wr_amp_i;
        end else begin
          if (shift_x_i)
            pos_ff[i] <= pos_ff[i] + shift_w_i;
          if (shift_y_i)
            amp_ff[i] <= amp_ff[i] + shift_h_i;
        end
      end
    end
  end
  always @* begin
    rd_pos_o = pos_ff[rd_idx_i];
    rd_amp_o = amp_ff[rd_idx_i];
  end
endmodule // mask_point_store
`default_nettype wire

// *** trig_out_port.v ***
// trigger output port: type, idle level (user type only), pulse length, direction
`timescale 1ns/1ps
`default_nettype none
`include "spectral_limit_trigger_defs.vh"
module trig_out_port #(
  parameter LW = 16
) (
  input  wire          clk_sys_i,
  input  wire          rst_n_i,
  input  wire          dir_out_i,
  input  wire [1:0]    otype_i,
  input  wire          idle_level_i,
  input  wire [LW-1:0] pulse_len_i,
  input  wire          dev_trig_i,
  input  wire          armed_i,
  input  wire          send_i,
  input  wire          pin_i,
  output reg           pin_o,
  output reg           pin_oe_o,
  output wire          ext_trig_o
);
  reg [LW-1:0] cnt_ff;
  wire         start = (otype_i == `OTYPE_DEVICE && dev_trig_i) ||
                       (otype_i == `OTYPE_USER && send_i);
  // as input the pin feeds the external trigger source
  assign ext_trig_o = dir_out_i ? 1'b0 : pin_i;
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff   <= {LW{1'b0}};
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end else begin
      pin_oe_o <= dir_out_i;
      // the start cycle is the first pulse cycle, so the counter holds the rest
      if (start && pulse_len_i != {LW{1'b0}})
        cnt_ff <= pulse_len_i - {{(LW-1){1'b0}}, 1'b1};
      else if (cnt_ff != {LW{1'b0}})
        cnt_ff <= cnt_ff - {{(LW-1){1'b0}}, 1'b1};
      case (otype_i)
        `OTYPE_ARMED: pin_o <= armed_i;
        `OTYPE_USER:  pin_o <= (cnt_ff != {LW{1'b0}} ||
                                (start && pulse_len_i != {LW{1'b0}})) ?
                               ~idle_level_i : idle_level_i;
        default:      pin_o <= (cnt_ff != {LW{1'b0}} ||
                                (start && pulse_len_i != {LW{1'b0}}));
      endcase
    end
  end
endmodule // trig_out_port
`default_nettype wire

// *** slt_monitor.sv ***
// concurrent checks on the spectral limit trigger ports
`timescale 1ns/1ps
`default_nettype none
module slt_monitor #(
  parameter LW = 16
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_n_i,
  input  wire logic [2:0]    trig_source_i,
  input  wire logic          mask_cond_i,
  input  wire logic          bin_valid_i,
  input  wire logic          bin_last_i,
  input  wire logic          trig2_dir_out_i,
  input  wire logic [1:0]    trig2_otype_i,
  input  wire logic [LW-1:0] trig2_pulse_len_i,
  input  wire logic          trig3_dir_out_i,
  input  wire logic [1:0]    trig3_otype_i,
  input  wire logic          trig3_level_i,
  input  wire logic [LW-1:0] trig3_pulse_len_i,
  input  wire logic          trig3_send_i,
  input  wire logic          trig2_pin_o,
  input  wire logic          trig2_pin_oe_o,
  input  wire logic          trig3_pin_o,
  input  wire logic          capture_trig_o,
  input  wire logic          mask_armed_o,
  input  wire logic          frame_inside_o,
  input  wire logic [15:0]   oper_status_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  logic [LW-1:0] high_cnt_ff;

  // length of the current port 2 pulse, compared when it ends
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i)
      high_cnt_ff <= '0;
    else if (trig2_pin_o)
      high_cnt_ff <= high_cnt_ff + 1'b1;
    else
      high_cnt_ff <= '0;
  end

  a_fire_at_end: assert property (capture_trig_o |-> $past(bin_valid_i && bin_last_i))
    else $error("capture trigger without a frame end");
  a_fire_one_cycle: assert property (capture_trig_o |=> !capture_trig_o)
    else $error("capture trigger longer than one cycle");
  a_fire_needs_src: assert property (capture_trig_o |-> $past(trig_source_i) == 3'h4)
    else $error("capture trigger while source is not the mask");
  a_fire_side: assert property (capture_trig_o |-> frame_inside_o == !$past(mask_cond_i))
    else $error("capture trigger on the wrong side of the mask");
  a_status_armed: assert property (oper_status_o == {10'h000, mask_armed_o, 5'h00})
    else $error("status word does not mirror armed state");
  a_oe_follows_dir: assert property ($past(rst_n_i) |-> trig2_pin_oe_o == $past(trig2_dir_out_i))
    else $error("port 2 enable does not follow direction");
  a_dev_pulse_start: assert property (capture_trig_o && trig2_otype_i == 2'h0 && trig2_dir_out_i
      && trig2_pulse_len_i != '0 && !trig2_pin_o |=> trig2_pin_o)
    else $error("port 2 pulse did not follow capture");
  a_pulse_width: assert property ($fell(trig2_pin_o) && trig2_otype_i == 2'h0
      |-> high_cnt_ff == trig2_pulse_len_i)
    else $error("port 2 pulse width differs from length");
  a_send_pulse: assert property (trig3_otype_i == 2'h2 && trig3_dir_out_i && trig3_send_i
      && trig3_pulse_len_i != '0 && trig3_pin_o == trig3_level_i
      |=> trig3_pin_o == !trig3_level_i)
    else $error("port 3 send did not start an opposite pulse");
  a_armed_out: assert property ($past(rst_n_i) && $past(trig2_otype_i) == 2'h1
      |-> trig2_pin_o == $past(mask_armed_o))
    else $error("port 2 armed output differs from armed state");
endmodule // slt_monitor
`default_nettype wire

// *** spectrum_source.sv ***
// spectrum pipeline model: one flat frame of four bins per start
`timescale 1ns/1ps
`default_nettype none
module spectrum_source (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic [15:0] amp_i,
  output logic             bin_valid_o,
  output logic [15:0]      bin_pos_o,
  output logic [15:0]      bin_amp_o,
  output logic             bin_last_o
);
  logic [2:0]  bin_ff;
  logic [15:0] junk_ff;

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bin_ff  <= 3'h0;
      junk_ff <= 16'h5a5a;
    end else begin
      junk_ff <= ~junk_ff;
      if (start_i || (bin_ff != 3'h0 && bin_ff != 3'h4))
        bin_ff <= bin_ff + 3'h1;
      else
        bin_ff <= 3'h0;
    end
  end

  // between frames the bus toggles so a stale bin is never reused
  assign bin_valid_o = (bin_ff != 3'h0);
  assign bin_last_o  = (bin_ff == 3'h4);
  assign bin_pos_o   = bin_valid_o ? {9'h000, bin_ff, 4'h0} : junk_ff;
  assign bin_amp_o   = bin_valid_o ? amp_i : ~junk_ff;
endmodule // spectrum_source
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the spectral limit trigger
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam LW = 16;
  logic        clk_sys_i, rst_n_i, slope_falling_i, mask_cond_i, upper_sel_i, lower_sel_i;
  logic        rel_mode_i, pt_wr_i, pt_wr_lower_i, shift_x_i, shift_y_i, shift_lower_i;
  logic        auto_set_i, bin_valid_i, bin_last_i, level_src_i, trig1_pin_i, trig2_pin_i;
  logic        trig2_dir_out_i, trig3_dir_out_i, trig2_level_i, trig3_level_i, trig3_pin_i;
  logic        trig2_send_i, trig3_send_i, trig2_pin_o, trig2_pin_oe_o, trig3_pin_o;
  logic        trig3_pin_oe_o, capture_trig_o, mask_armed_o, frame_inside_o, start, fired;
  logic [1:0]  trig2_otype_i, trig3_otype_i;
  logic [2:0]  trig_source_i;
  logic [9:0]  pt_idx_i;
  logic [10:0] upper_count_i, lower_count_i;
  logic [15:0] ref_level_i, auto_dist_i, pt_pos_i, pt_amp_i, shift_w_i, shift_h_i;
  logic [15:0] bin_pos_i, bin_amp_i, trig2_pulse_len_i, trig3_pulse_len_i;
  logic [15:0] oper_status_o, amp, width;
  int          bad_count, n_tests;

  spectral_limit_trigger spectral_limit_trigger_inst (.*);
  spectrum_source spectrum_source_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .start_i(start), .amp_i(amp), .bin_valid_o(bin_valid_i), .bin_pos_o(bin_pos_i),
    .bin_amp_o(bin_amp_i), .bin_last_o(bin_last_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  task stop_test;
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task wr_pt(input logic lo, input logic [9:0] idx, input logic [15:0] pos, input logic [15:0] a);
    @(posedge clk_sys_i);
    pt_wr_i       <= 1'b1;
    pt_wr_lower_i <= lo;
    pt_idx_i      <= idx;
    pt_pos_i      <= pos;
    pt_amp_i      <= a;
    @(posedge clk_sys_i);
    pt_wr_i       <= 1'b0;
  endtask

  // reset between cases clears any armed state left from the last one
  task setup(input logic [2:0] src, input logic cond, input logic us, input logic ls,
             input logic [10:0] cnt, input logic rel, input logic [1:0] ot2);
    @(posedge clk_sys_i);
    rst_n_i       <= 1'b0;
    trig_source_i <= src;
    mask_cond_i   <= cond;
    upper_sel_i   <= us;
    lower_sel_i   <= ls;
    upper_count_i <= cnt;
    rel_mode_i    <= rel;
    trig2_otype_i <= ot2;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i       <= 1'b1;
    wr_pt(1'b0, 10'h000, 16'h0000, 16'h0064);
    wr_pt(1'b0, 10'h001, 16'h0100, 16'h0064);
    wr_pt(1'b1, 10'h000, 16'h0000, 16'h0014);
    wr_pt(1'b1, 10'h001, 16'h0100, 16'h0014);
  endtask

  task shift(input logic y, input logic [15:0] v);
    @(posedge clk_sys_i);
    shift_x_i <= !y;
    shift_y_i <= y;
    shift_w_i <= v;
    shift_h_i <= v;
    @(posedge clk_sys_i);
    shift_x_i <= 1'b0;
    shift_y_i <= 1'b0;
  endtask

  task frame(input logic [15:0] a);
    @(posedge clk_sys_i);
    amp   <= a;
    start <= 1'b1;
    @(posedge clk_sys_i);
    start <= 1'b0;
    fired = 1'b0;
    width = 16'h0000;
    repeat (30) begin
      @(posedge clk_sys_i);
      #1;
      if (capture_trig_o === 1'b1)
        fired = 1'b1;
      if (trig2_pin_o === 1'b1)
        width = width + 16'h0001;
    end
  endtask

  task run_case(input logic [2:0] src, input logic cond, input logic us, input logic ls,
                input logic [10:0] cnt, input logic rel, input logic [15:0] a1,
                input logic [15:0] a2, input logic exp);
    logic arm;
    // every first frame lies on the arming side: only source and count decide
    arm = (src == 3'h4) && (cnt >= 11'h002) && (cnt <= 11'h3e9);
    setup(src, cond, us, ls, cnt, rel, 2'h0);
    frame(a1);
    chk("mask_armed_o", {15'h0000, arm}, {15'h0000, mask_armed_o});
    chk("oper_status_o bit 5", {15'h0000, arm}, {15'h0000, oper_status_o[5]});
    frame(a2);
    chk("capture_trig_o", {15'h0000, exp}, {15'h0000, fired});
    chk("trig2 pulse width", exp ? 16'h0003 : 16'h0000, width);
  endtask

  initial begin
    {rst_n_i, slope_falling_i, mask_cond_i, upper_sel_i, lower_sel_i, rel_mode_i, pt_wr_i,
     pt_wr_lower_i, shift_x_i, shift_y_i, shift_lower_i, auto_set_i, level_src_i, trig1_pin_i,
     trig2_pin_i, trig3_pin_i, trig2_level_i, trig2_send_i, trig3_send_i, start, trig2_otype_i,
     trig_source_i, pt_idx_i, pt_pos_i, pt_amp_i, shift_w_i, shift_h_i, amp} = '0;
    {bad_count, n_tests} = '0;
    trig2_dir_out_i = 1'b1;
    trig3_dir_out_i = 1'b1;
    trig3_otype_i = 2'h2;
    trig3_level_i = 1'b1;
    trig2_pulse_len_i = 16'h0003;
    trig3_pulse_len_i = 16'h0004;
    upper_count_i = 11'h002;
    lower_count_i = 11'h002;
    ref_level_i = 16'h0064;
    auto_dist_i = 16'h000a;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("trig3 idle level", 16'h0001, {15'h0000, trig3_pin_o});
    chk("trig3 output enable", 16'h0001, {15'h0000, trig3_pin_oe_o});
    @(posedge clk_sys_i);
    trig3_send_i <= 1'b1;
    @(posedge clk_sys_i);
    trig3_send_i <= 1'b0;
    width = 16'h0000;
    // the first low cycle starts at the edge that takes the send
    repeat (12) begin
      #1;
      if (trig3_pin_o === 1'b0)
        width = width + 16'h0001;
      @(posedge clk_sys_i);
    end
    chk("trig3 pulse width", 16'h0004, width);
    run_case(3'h4, 1'b0, 1'b1, 1'b0, 11'h002, 1'b0, 16'h0032, 16'h0096, 1'b1);
    run_case(3'h0, 1'b0, 1'b1, 1'b0, 11'h002, 1'b0, 16'h0032, 16'h0096, 1'b0);
    run_case(3'h4, 1'b1, 1'b1, 1'b0, 11'h002, 1'b0, 16'h0096, 16'h0032, 1'b1);
    run_case(3'h4, 1'b0, 1'b0, 1'b1, 11'h002, 1'b0, 16'h0032, 16'h000a, 1'b1);
    run_case(3'h4, 1'b0, 1'b0, 1'b1, 11'h002, 1'b0, 16'h0032, 16'h0096, 1'b0);
    @(posedge clk_sys_i) slope_falling_i <= 1'b1;
    run_case(3'h4, 1'b0, 1'b1, 1'b1, 11'h002, 1'b0, 16'h0032, 16'h000a, 1'b1);
    run_case(3'h4, 1'b0, 1'b1, 1'b0, 11'h001, 1'b0, 16'h0032, 16'h0096, 1'b0);
    run_case(3'h4, 1'b0, 1'b1, 1'b0, 11'h3ea, 1'b0, 16'h0032, 16'h0096, 1'b0);
    run_case(3'h4, 1'b0, 1'b1, 1'b0, 11'h002, 1'b1, 16'h0096, 16'h00fa, 1'b1);
    setup(3'h4, 1'b0, 1'b1, 1'b0, 11'h002, 1'b0, 2'h1);
    shift(1'b1, 16'h0064);
    frame(16'h0032);
    chk("trig2 armed level", 16'h0001, {15'h0000, trig2_pin_o});
    frame(16'h0096);
    chk("capture below raised mask", 16'h0000, {15'h0000, fired});
    frame(16'h00fa);
    chk("capture above raised mask", 16'h0001, {15'h0000, fired});
    setup(3'h4, 1'b0, 1'b1, 1'b0, 11'h002, 1'b0, 2'h0);
    shift(1'b0, 16'h0200);
    frame(16'h0032);
    frame(16'h00fa);
    chk("capture with mask off the bins", 16'h0000, {15'h0000, fired});
    setup(3'h4, 1'b0, 1'b1, 1'b0, 11'h002, 1'b0, 2'h0);
    @(posedge clk_sys_i);
    auto_set_i <= 1'b1;
    @(posedge clk_sys_i);
    auto_set_i <= 1'b0;
    frame(16'h0032);
    @(posedge clk_sys_i);
    upper_count_i <= 11'h004;
    frame(16'h0046);
    chk("capture over learned mask", 16'h0001, {15'h0000, fired});
    stop_test;
  end

  // a hang is cut short and counted as a mismatch
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    stop_test;
  end
endmodule // tb

bind spectral_limit_trigger slt_monitor #(.LW(LW)) slt_monitor_inst (.*);
`default_nettype wire
